// ==== include/sph_pkg.sv ====
// constants and types shared by the packet header, crc and hopping control
package sph_pkg;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int PL_W = 8;
  localparam int SF_W = 4;
  localparam int CR_W = 3;
  localparam int PRE_W = 16;
  localparam int HOP_W = 8;
  localparam int CH_W = 6;
  localparam int NSYM_W = 12;
  localparam int PREQ_W = 19;
  localparam int TOA_W = 20;

  // ---------------------------------------------------------------
  // legal ranges and fixed codes
  // ---------------------------------------------------------------
  localparam logic [PL_W-1:0] PL_MIN = 8'h01;
  localparam logic [SF_W-1:0] SF_MIN = 4'h6;
  localparam logic [SF_W-1:0] SF_MAX = 4'hc;
  localparam logic [SF_W-1:0] SF_IMPLICIT_ONLY = 4'h6;
  localparam logic [CR_W-1:0] CR_MIN = 3'h1;
  localparam logic [CR_W-1:0] CR_MAX = 3'h4;
  // the header always goes out at the strongest code, 4/8
  localparam logic [CR_W-1:0] HDR_CR = 3'h4;
  localparam logic [CH_W-1:0] CH_FIRST = 6'h00;

  // ---------------------------------------------------------------
  // symbol count arithmetic
  // ---------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam int SF_COEF = 4;
  localparam int NUM_OFS = 28;
  localparam int CRC_BITS = 16;
  localparam int IH_BITS = 20;
  localparam int DEN_COEF = 4;
  localparam int DE_COEF = 2;
  localparam int CR_OFS = 4;
  localparam int BASE_SYMS = 8;
  // preamble overhead of 4.25 symbols kept in quarter symbols
  localparam logic [PREQ_W-1:0] PRE_FIX_Q = 19'h00011;

  // ---------------------------------------------------------------
  // hopping sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SPH_IDLE = 2'b00,
    SPH_SEARCH = 2'b01,
    SPH_HEAD = 2'b10,
    SPH_HOP = 2'b11
  } sph_state_t;

endpackage

// ==== logic/sph_payload_calc.sv ====
// payload symbol count for the current packet format
`timescale 1ns/100ps
module sph_payload_calc (
  input wire logic [sph_pkg::PL_W-1:0] pay_len,
  input wire logic [sph_pkg::SF_W-1:0] sf,
  input wire logic [sph_pkg::CR_W-1:0] cr,
  input wire logic crc_on,
  input wire logic no_header,
  input wire logic low_rate,
  output logic [sph_pkg::NSYM_W-1:0] n_payload
);

  // ---------------------------------------------------------------
  // 8 + max(ceil(num / den) * (cr + 4), 0)
  // ---------------------------------------------------------------
  // a non-positive numerator or denominator yields the bare 8 symbols,
  // so an illegal spreading factor cannot divide by zero
  function automatic int sym_count(input int pl, input int s, input int c,
                                   input bit crc, input bit ih, input bit de);
    int num;
    int den;
    int quo;
    num = sph_pkg::BITS_PER_BYTE * pl - sph_pkg::SF_COEF * s + sph_pkg::NUM_OFS;
    if (crc) begin
      num = num + sph_pkg::CRC_BITS;
    end
    if (ih) begin
      num = num - sph_pkg::IH_BITS;
    end
    den = s;
    if (de) begin
      den = den - sph_pkg::DE_COEF;
    end
    den = sph_pkg::DEN_COEF * den;
    if (num <= 0 || den <= 0) begin
      quo = 0;
    end else begin
      quo = (num + den - 1) / den;
    end
    sym_count = sph_pkg::BASE_SYMS + quo * (c + sph_pkg::CR_OFS);
  endfunction

  always_comb begin
    n_payload = sph_pkg::NSYM_W'(sym_count(int'(pay_len), int'(sf), int'(cr),
                                           crc_on, no_header, low_rate));
  end

endmodule

// ==== logic/sph_packet_ctrl.sv ====
// packet format, payload crc policy, air-time arithmetic and hop sequencing
`timescale 1ns/100ps
module sph_packet_ctrl #(
  parameter int HOP_W = sph_pkg::HOP_W,
  parameter int CH_W = sph_pkg::CH_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic implicit_header_select,
  input wire logic payload_crc_enable,
  input wire logic low_rate_optimise,
  input wire logic [sph_pkg::SF_W-1:0] spread_factor,
  input wire logic [sph_pkg::CR_W-1:0] coding_rate,
  input wire logic [sph_pkg::PL_W-1:0] payload_length,
  input wire logic [7:0] preamble_len_upper,
  input wire logic [7:0] preamble_len_lower,
  input wire logic [HOP_W-1:0] hop_period_symbols,
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic preamble_detected,
  input wire logic header_received,
  input wire logic [sph_pkg::PL_W-1:0] hdr_length,
  input wire logic [sph_pkg::CR_W-1:0] hdr_coding_rate,
  input wire logic hdr_crc_present,
  input wire logic header_crc_bad,
  input wire logic payload_start,
  input wire logic symbol_tick,
  input wire logic payload_done,
  input wire logic payload_crc_ok,
  input wire logic packet_end,
  input wire logic hop_irq_clear,
  input wire logic crc_err_clear,
  output logic tx_header_on_ff,
  output logic tx_crc_append_ff,
  output logic [sph_pkg::CR_W-1:0] header_coding_rate_ff,
  output logic [sph_pkg::PL_W-1:0] rx_length_ff,
  output logic [sph_pkg::CR_W-1:0] rx_coding_rate_ff,
  output logic rx_crc_present_ff,
  output logic payload_crc_error_flag_ff,
  output logic cfg_invalid_ff,
  output logic [sph_pkg::PREQ_W-1:0] preamble_quarters_ff,
  output logic [sph_pkg::NSYM_W-1:0] payload_symbols_ff,
  output logic [sph_pkg::TOA_W-1:0] time_on_air_quarters_ff,
  output logic hop_active_ff,
  output logic [CH_W-1:0] present_channel_count_ff,
  output logic change_channel_irq_ff,
  output logic freq_switch_ff,
  output logic detect_restart_ff
);

  // ---------------------------------------------------------------
  // internal state
  // ---------------------------------------------------------------
  sph_pkg::sph_state_t state_ff;
  sph_pkg::sph_state_t nxt_state;
  logic is_rx_ff;
  logic [HOP_W-1:0] hop_cnt_ff;
  logic hop_en;
  logic hop_due;
  logic hdr_bad;
  logic crc_check;
  logic crc_err_set;
  logic [sph_pkg::NSYM_W-1:0] calc_symbols;
  logic [sph_pkg::PREQ_W-1:0] nxt_preamble_q;
  logic [sph_pkg::TOA_W-1:0] nxt_toa_q;

  // ---------------------------------------------------------------
  // header format and transmit crc policy
  // ---------------------------------------------------------------
  // the header is omitted only when implicit mode is selected; reset
  // leaves the explicit format in place
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_header_on_ff <= 1'b1;
      tx_crc_append_ff <= 1'b0;
      header_coding_rate_ff <= sph_pkg::HDR_CR;
    end else begin
      tx_header_on_ff <= !implicit_header_select;
      tx_crc_append_ff <= payload_crc_enable;
      header_coding_rate_ff <= sph_pkg::HDR_CR;
    end
  end

  // ---------------------------------------------------------------
  // receive format: from header or from local configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_length_ff <= sph_pkg::PL_MIN;
      rx_coding_rate_ff <= sph_pkg::CR_MIN;
    end else if (rx_start && implicit_header_select) begin
      rx_length_ff <= payload_length;
      rx_coding_rate_ff <= coding_rate;
    end else if (header_received && is_rx_ff && !implicit_header_select) begin
      rx_length_ff <= hdr_length;
      rx_coding_rate_ff <= hdr_coding_rate;
    end
  end

  // crc presence follows the received header only in explicit mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_crc_present_ff <= 1'b0;
    end else if (header_received && is_rx_ff && !implicit_header_select) begin
      rx_crc_present_ff <= hdr_crc_present;
    end
  end

  // ---------------------------------------------------------------
  // payload crc error flag
  // ---------------------------------------------------------------
  // explicit: the header decides and the local enable is ignored;
  // implicit: the local enable decides, so a silent transmitter makes
  // every check fail, which is the expected penalty for a mismatch
  always_comb begin
    if (implicit_header_select) begin
      crc_check = payload_crc_enable;
    end else begin
      crc_check = rx_crc_present_ff;
    end
    crc_err_set = payload_done && is_rx_ff && crc_check && !payload_crc_ok;
  end

  // a new error in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      payload_crc_error_flag_ff <= 1'b0;
    end else if (crc_err_set) begin
      payload_crc_error_flag_ff <= 1'b1;
    end else if (crc_err_clear) begin
      payload_crc_error_flag_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration sanity
  // ---------------------------------------------------------------
  // only reported; the block keeps running so software sees the flag
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_invalid_ff <= 1'b0;
    end else begin
      cfg_invalid_ff <= (payload_length < sph_pkg::PL_MIN) ||
                        (spread_factor < sph_pkg::SF_MIN) ||
                        (spread_factor > sph_pkg::SF_MAX) ||
                        (coding_rate < sph_pkg::CR_MIN) ||
                        (coding_rate > sph_pkg::CR_MAX) ||
                        ((spread_factor == sph_pkg::SF_IMPLICIT_ONLY) &&
                         !implicit_header_select);
    end
  end

  // ---------------------------------------------------------------
  // air-time arithmetic, in quarter symbols
  // ---------------------------------------------------------------
  sph_payload_calc u_calc (
    .pay_len(payload_length),
    .sf(spread_factor),
    .cr(coding_rate),
    .crc_on(payload_crc_enable),
    .no_header(implicit_header_select),
    .low_rate(low_rate_optimise),
    .n_payload(calc_symbols)
  );

  always_comb begin
    nxt_preamble_q = {1'b0, preamble_len_upper, preamble_len_lower, 2'b00} +
                     sph_pkg::PRE_FIX_Q;
    nxt_toa_q = sph_pkg::TOA_W'(nxt_preamble_q) +
                sph_pkg::TOA_W'({calc_symbols, 2'b00});
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preamble_quarters_ff <= '0;
      payload_symbols_ff <= '0;
      time_on_air_quarters_ff <= '0;
    end else begin
      preamble_quarters_ff <= nxt_preamble_q;
      payload_symbols_ff <= calc_symbols;
      time_on_air_quarters_ff <= nxt_toa_q;
    end
  end

  // ---------------------------------------------------------------
  // hop sequencer
  // ---------------------------------------------------------------
  always_comb begin
    hop_en = (hop_period_symbols != '0);
    hdr_bad = header_crc_bad && is_rx_ff && (state_ff != sph_pkg::SPH_IDLE);
    // a bad header sends the receiver back to channel 0, so no hop is flagged then
    hop_due = (state_ff == sph_pkg::SPH_HOP) && hop_en && symbol_tick && !hdr_bad &&
              ({1'b0, hop_cnt_ff} + {{HOP_W{1'b0}}, 1'b1} ==
               {1'b0, hop_period_symbols});
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sph_pkg::SPH_IDLE: begin
        nxt_state = sph_pkg::SPH_IDLE;
      end
      sph_pkg::SPH_SEARCH: begin
        if (preamble_detected) begin
          nxt_state = sph_pkg::SPH_HEAD;
        end
      end
      sph_pkg::SPH_HEAD: begin
        if (payload_start) begin
          nxt_state = sph_pkg::SPH_HOP;
        end
      end
      sph_pkg::SPH_HOP: begin
        nxt_state = sph_pkg::SPH_HOP;
      end
      default: begin
        nxt_state = sph_pkg::SPH_IDLE;
      end
    endcase
    if (hdr_bad) begin
      nxt_state = sph_pkg::SPH_SEARCH;
    end
    if (packet_end) begin
      nxt_state = sph_pkg::SPH_IDLE;
    end
    // a start overrides everything so a new packet is never lost
    if (tx_start) begin
      nxt_state = sph_pkg::SPH_HEAD;
    end else if (rx_start) begin
      nxt_state = sph_pkg::SPH_SEARCH;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= sph_pkg::SPH_IDLE;
      is_rx_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (tx_start) begin
        is_rx_ff <= 1'b0;
      end else if (rx_start) begin
        is_rx_ff <= 1'b1;
      end
    end
  end

  // dwell counter runs on symbol boundaries only while hopping
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hop_cnt_ff <= '0;
    end else if (state_ff != sph_pkg::SPH_HOP || tx_start || rx_start) begin
      hop_cnt_ff <= '0;
    end else if (hop_en && symbol_tick) begin
      hop_cnt_ff <= hop_due ? '0 : hop_cnt_ff + 1'b1;
    end
  end

  // channel counter wraps at its width; the host owns the frequency table
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      present_channel_count_ff <= sph_pkg::CH_FIRST;
    end else if (tx_start || rx_start || hdr_bad) begin
      present_channel_count_ff <= sph_pkg::CH_FIRST;
    end else if (hop_due) begin
      present_channel_count_ff <= present_channel_count_ff + 1'b1;
    end
  end

  // flag and switch strobe share one edge; set wins over the host clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      change_channel_irq_ff <= 1'b0;
    end else if (hop_due) begin
      change_channel_irq_ff <= 1'b1;
    end else if (hop_irq_clear) begin
      change_channel_irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      freq_switch_ff <= 1'b0;
      detect_restart_ff <= 1'b0;
      hop_active_ff <= 1'b0;
    end else begin
      freq_switch_ff <= hop_due;
      detect_restart_ff <= hdr_bad;
      hop_active_ff <= (nxt_state == sph_pkg::SPH_HOP) && hop_en;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_hop_seen;
    ##1 (change_channel_irq_ff && freq_switch_ff);
  endsequence

  sequence s_restart_seen;
    ##1 (state_ff == sph_pkg::SPH_SEARCH && detect_restart_ff &&
         present_channel_count_ff == sph_pkg::CH_FIRST);
  endsequence

  property p_hop_irq;
    @(posedge clk_sys) disable iff (!rst_b) hop_due |-> s_hop_seen;
  endproperty
  a_hop_irq: assert property (p_hop_irq) else $error("hop without flag");

  property p_chan_inc;
    @(posedge clk_sys) disable iff (!rst_b)
      freq_switch_ff && !$past(tx_start) && !$past(rx_start) |->
      present_channel_count_ff == $past(present_channel_count_ff) + 1'b1;
  endproperty
  a_chan_inc: assert property (p_chan_inc) else $error("channel not advanced");

  property p_head_ch0;
    @(posedge clk_sys) disable iff (!rst_b)
      state_ff == sph_pkg::SPH_HEAD |-> present_channel_count_ff == sph_pkg::CH_FIRST;
  endproperty
  a_head_ch0: assert property (p_head_ch0) else $error("header off channel 0");

  property p_no_hop_off;
    @(posedge clk_sys) disable iff (!rst_b)
      hop_period_symbols == '0 |=> !freq_switch_ff;
  endproperty
  a_no_hop_off: assert property (p_no_hop_off) else $error("hop while disabled");

  property p_crc_silent;
    @(posedge clk_sys) disable iff (!rst_b)
      payload_done && !implicit_header_select && !rx_crc_present_ff &&
      !payload_crc_error_flag_ff |=> !payload_crc_error_flag_ff;
  endproperty
  a_crc_silent: assert property (p_crc_silent) else $error("crc error without crc");

  property p_crc_err;
    @(posedge clk_sys) disable iff (!rst_b)
      payload_done && is_rx_ff && !payload_crc_ok &&
      (implicit_header_select ? payload_crc_enable : rx_crc_present_ff)
      |=> payload_crc_error_flag_ff [*1];
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("crc error missed");

  property p_hdr_bad;
    @(posedge clk_sys) disable iff (!rst_b)
      header_crc_bad && is_rx_ff && state_ff != sph_pkg::SPH_IDLE &&
      !tx_start && !rx_start && !packet_end |-> s_restart_seen;
  endproperty
  a_hdr_bad: assert property (p_hdr_bad) else $error("no restart on bad header");

  property p_preamble;
    @(posedge clk_sys) disable iff (!rst_b)
      $stable({preamble_len_upper, preamble_len_lower}) |=>
      preamble_quarters_ff == {1'b0, $past(preamble_len_upper),
                               $past(preamble_len_lower), 2'b00} + sph_pkg::PRE_FIX_Q;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble time wrong");

  property p_rx_wait;
    @(posedge clk_sys) disable iff (!rst_b)
      state_ff == sph_pkg::SPH_SEARCH && !preamble_detected |=>
      state_ff != sph_pkg::SPH_HOP;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("hop before preamble");

  property p_dwell;
    @(posedge clk_sys) disable iff (!rst_b)
      state_ff == sph_pkg::SPH_HOP && hop_en && $stable(hop_period_symbols) |->
      hop_cnt_ff < hop_period_symbols;
  endproperty
  a_dwell: assert property (p_dwell) else $error("dwell overrun");

endmodule

// ==== test/sph_remote_radio.sv ====
// remote radio model: drives the receive-side event pulses of the block
`timescale 1ns/100ps
module sph_remote_radio (
  input wire logic clk_sys,
  output logic preamble_detected,
  output logic header_received,
  output logic [sph_pkg::PL_W-1:0] hdr_length,
  output logic [sph_pkg::CR_W-1:0] hdr_coding_rate,
  output logic hdr_crc_present,
  output logic header_crc_bad,
  output logic payload_start,
  output logic symbol_tick,
  output logic payload_done,
  output logic payload_crc_ok,
  output logic packet_end
);
  logic [6:0] ev = 7'h00;
  assign {preamble_detected, payload_start, symbol_tick, packet_end} = ev[6:3];
  assign {payload_done, header_received, header_crc_bad} = ev[2:0];
  initial begin
    {hdr_length, hdr_coding_rate, hdr_crc_present, payload_crc_ok} = 13'h0000;
  end
  // one strobe, one cycle wide; the ok line is junk outside its strobe
  task automatic pulse(input int idx, input logic ok);
    @(posedge clk_sys);
    ev[idx] <= 1'b1;
    payload_crc_ok <= ok;
    @(posedge clk_sys);
    ev[idx] <= 1'b0;
    payload_crc_ok <= ~ok;
    #1;
  endtask
  // header fields are driven inverted once the strobe has gone
  task automatic header(input logic [7:0] len, input logic [2:0] cr, input logic crc);
    @(posedge clk_sys);
    ev[1] <= 1'b1;
    {hdr_length, hdr_coding_rate, hdr_crc_present} <= {len, cr, crc};
    @(posedge clk_sys);
    ev[1] <= 1'b0;
    {hdr_length, hdr_coding_rate, hdr_crc_present} <= ~{len, cr, crc};
    #1;
  endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the packet format and hop control block
`timescale 1ns/100ps
module testbench;
  localparam int PRE = 6, PST = 5, TCK = 4, PEND = 3, DONE = 2, BAD = 0;
  localparam int TX = 3, RX = 2, HCLR = 1, CCLR = 0;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic implicit_header_select = 1'b0, payload_crc_enable = 1'b0, low_rate_optimise = 1'b0;
  logic [3:0] spread_factor = 4'h7;
  logic [2:0] coding_rate = 3'h1;
  logic [7:0] payload_length = 8'h0a, preamble_len_upper = 8'h00, preamble_len_lower = 8'h08;
  logic [7:0] hop_period_symbols = 8'h00;
  logic [3:0] hv = 4'h0;
  logic tx_start, rx_start, hop_irq_clear, crc_err_clear;
  logic preamble_detected, header_received, hdr_crc_present, header_crc_bad, payload_start;
  logic symbol_tick, payload_done, payload_crc_ok, packet_end;
  logic [7:0] hdr_length, rx_length_ff;
  logic [2:0] hdr_coding_rate, header_coding_rate_ff, rx_coding_rate_ff;
  logic tx_header_on_ff, tx_crc_append_ff, rx_crc_present_ff, payload_crc_error_flag_ff;
  logic cfg_invalid_ff, hop_active_ff, change_channel_irq_ff, freq_switch_ff, detect_restart_ff;
  logic [18:0] preamble_quarters_ff;
  logic [11:0] payload_symbols_ff;
  logic [19:0] time_on_air_quarters_ff;
  logic [5:0] present_channel_count_ff;
  int num_errors = 0;
  int n_checks = 0;
  int tbl[9][7] = '{'{10, 7, 1, 1, 0, 0, 8}, '{255, 12, 4, 1, 0, 1, 65535},
    '{1, 12, 3, 0, 1, 0, 6}, '{20, 6, 2, 0, 1, 0, 12}, '{20, 6, 2, 0, 0, 0, 12},
    '{0, 7, 1, 0, 0, 0, 12}, '{10, 13, 1, 0, 0, 0, 12}, '{10, 7, 5, 0, 0, 0, 12},
    '{10, 7, 0, 0, 0, 0, 12}};
  assign {tx_start, rx_start, hop_irq_clear, crc_err_clear} = hv;
  always #2.5 clk_sys = ~clk_sys;
  sph_packet_ctrl dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .tx_start(tx_start), .rx_start(rx_start),
    .implicit_header_select(implicit_header_select), .payload_crc_enable(payload_crc_enable),
    .low_rate_optimise(low_rate_optimise), .spread_factor(spread_factor),
    .coding_rate(coding_rate), .payload_length(payload_length),
    .preamble_len_upper(preamble_len_upper), .preamble_len_lower(preamble_len_lower),
    .hop_period_symbols(hop_period_symbols), .preamble_detected(preamble_detected),
    .header_received(header_received), .hdr_length(hdr_length),
    .hdr_coding_rate(hdr_coding_rate), .hdr_crc_present(hdr_crc_present),
    .header_crc_bad(header_crc_bad), .payload_start(payload_start), .symbol_tick(symbol_tick),
    .payload_done(payload_done), .payload_crc_ok(payload_crc_ok), .packet_end(packet_end),
    .hop_irq_clear(hop_irq_clear), .crc_err_clear(crc_err_clear),
    .tx_header_on_ff(tx_header_on_ff), .tx_crc_append_ff(tx_crc_append_ff),
    .header_coding_rate_ff(header_coding_rate_ff), .rx_length_ff(rx_length_ff),
    .rx_coding_rate_ff(rx_coding_rate_ff), .rx_crc_present_ff(rx_crc_present_ff),
    .payload_crc_error_flag_ff(payload_crc_error_flag_ff), .cfg_invalid_ff(cfg_invalid_ff),
    .preamble_quarters_ff(preamble_quarters_ff), .payload_symbols_ff(payload_symbols_ff),
    .time_on_air_quarters_ff(time_on_air_quarters_ff), .hop_active_ff(hop_active_ff),
    .present_channel_count_ff(present_channel_count_ff),
    .change_channel_irq_ff(change_channel_irq_ff), .freq_switch_ff(freq_switch_ff),
    .detect_restart_ff(detect_restart_ff)
  );
  sph_remote_radio radio_u (
    .clk_sys(clk_sys), .preamble_detected(preamble_detected),
    .header_received(header_received), .hdr_length(hdr_length),
    .hdr_coding_rate(hdr_coding_rate), .hdr_crc_present(hdr_crc_present),
    .header_crc_bad(header_crc_bad), .payload_start(payload_start), .symbol_tick(symbol_tick),
    .payload_done(payload_done), .payload_crc_ok(payload_crc_ok), .packet_end(packet_end)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic hp(input int idx);
    @(posedge clk_sys);
    hv[idx] <= 1'b1;
    @(posedge clk_sys);
    hv[idx] <= 1'b0;
    #1;
  endtask
  task automatic cfg(input int pl, sf, cr, crc, ih, de, pre, hop);
    @(posedge clk_sys);
    payload_length <= pl[7:0];
    spread_factor <= sf[3:0];
    coding_rate <= cr[2:0];
    payload_crc_enable <= crc[0];
    implicit_header_select <= ih[0];
    low_rate_optimise <= de[0];
    {preamble_len_upper, preamble_len_lower} <= pre[15:0];
    hop_period_symbols <= hop[7:0];
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  function automatic int exp_pay(int pl, sf, cr, crc, ih, de);
    int num, den;
    num = 8 * pl - 4 * sf + 28 + 16 * crc - 20 * ih;
    den = 4 * (sf - 2 * de);
    if (num <= 0 || den <= 0) return 8;
    return 8 + ((num + den - 1) / den) * (cr + 4);
  endfunction
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_arith();
    int p, bad, pre;
    foreach (tbl[i]) begin
      cfg(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], tbl[i][5], tbl[i][6], 0);
      bad = tbl[i][0] < 1 || tbl[i][1] < 6 || tbl[i][1] > 12 || tbl[i][2] < 1 ||
        tbl[i][2] > 4 || (tbl[i][1] == 6 && tbl[i][4] == 0);
      chk(cfg_invalid_ff, bad);
      chk(tx_header_on_ff, !tbl[i][4]);
      chk(tx_crc_append_ff, tbl[i][3]);
      if (!bad) begin
        p = exp_pay(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], tbl[i][5]);
        pre = 4 * tbl[i][6] + 17;
        chk(preamble_quarters_ff, pre);
        chk(payload_symbols_ff, p);
        chk(time_on_air_quarters_ff, pre + 4 * p);
      end
    end
  endtask
  task automatic t_rx_exp();
    cfg(10, 7, 1, 0, 0, 0, 8, 0);
    hp(RX);
    radio_u.pulse(PRE, 1'b0);
    radio_u.header(8'h25, 3'h3, 1'b1);
    chk({rx_length_ff, rx_coding_rate_ff, rx_crc_present_ff}, {8'h25, 3'h3, 1'b1});
    radio_u.pulse(DONE, 1'b0);
    chk(payload_crc_error_flag_ff, 1);
    hp(CCLR);
    chk(payload_crc_error_flag_ff, 0);
    radio_u.pulse(PEND, 1'b0);
    cfg(10, 7, 1, 1, 0, 0, 8, 0);
    hp(RX);
    radio_u.pulse(PRE, 1'b0);
    radio_u.header(8'h14, 3'h2, 1'b0);
    radio_u.pulse(DONE, 1'b0);
    chk({rx_crc_present_ff, payload_crc_error_flag_ff}, 0);
    radio_u.pulse(PEND, 1'b0);
  endtask
  task automatic t_rx_imp();
    cfg(50, 7, 2, 0, 1, 0, 8, 0);
    hp(RX);
    chk({rx_length_ff, rx_coding_rate_ff}, {8'h32, 3'h2});
    radio_u.header(8'h09, 3'h1, 1'b1);
    chk(rx_length_ff, 8'h32);
    radio_u.pulse(DONE, 1'b0);
    chk(payload_crc_error_flag_ff, 0);
    cfg(50, 7, 2, 1, 1, 0, 8, 0);
    hp(RX);
    radio_u.pulse(DONE, 1'b0);
    chk(payload_crc_error_flag_ff, 1);
    hp(CCLR);
    radio_u.pulse(DONE, 1'b1);
    chk(payload_crc_error_flag_ff, 0);
    radio_u.pulse(PEND, 1'b0);
  endtask
  task automatic t_hop_tx();
    cfg(10, 7, 1, 1, 0, 0, 8, 2);
    hp(TX);
    radio_u.pulse(TCK, 1'b0);
    chk({present_channel_count_ff, hop_active_ff}, 0);
    radio_u.pulse(PST, 1'b0);
    chk(hop_active_ff, 1);
    radio_u.pulse(TCK, 1'b0);
    chk(present_channel_count_ff, 0);
    radio_u.pulse(TCK, 1'b0);
    chk({present_channel_count_ff, change_channel_irq_ff, freq_switch_ff}, 8'h07);
    @(posedge clk_sys);
    #1;
    chk({freq_switch_ff, change_channel_irq_ff}, 2'h1);
    hp(HCLR);
    chk(change_channel_irq_ff, 0);
    radio_u.pulse(PEND, 1'b0);
    cfg(10, 7, 1, 1, 0, 0, 8, 0);
    hp(TX);
    radio_u.pulse(PST, 1'b0);
    repeat (3) radio_u.pulse(TCK, 1'b0);
    chk({present_channel_count_ff, change_channel_irq_ff, hop_active_ff}, 0);
    radio_u.pulse(PEND, 1'b0);
  endtask
  task automatic t_hop_rx();
    cfg(10, 7, 1, 1, 0, 0, 8, 1);
    hp(RX);
    radio_u.pulse(TCK, 1'b0);
    chk({present_channel_count_ff, change_channel_irq_ff}, 0);
    radio_u.pulse(PRE, 1'b0);
    radio_u.pulse(PST, 1'b0);
    radio_u.pulse(TCK, 1'b0);
    chk(present_channel_count_ff, 1);
    radio_u.pulse(BAD, 1'b0);
    chk({present_channel_count_ff, detect_restart_ff}, 7'h01);
    hp(HCLR);
    radio_u.pulse(PEND, 1'b0);
  endtask
  initial begin
    // the held reset only acts at the first edge, so look just after it
    @(posedge clk_sys);
    #1;
    chk({tx_header_on_ff, header_coding_rate_ff, rx_length_ff, rx_coding_rate_ff}, 15'h6009);
    chk({payload_crc_error_flag_ff, present_channel_count_ff, change_channel_irq_ff}, 0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    t_arith();
    t_rx_exp();
    t_rx_imp();
    t_hop_tx();
    t_hop_rx();
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
